// ---- verilog/power_mode_clock_switch.sv ----
// power-mode sequencer and clock source selector
// assumes oscillator ready levels and count ticks come from other clock domains
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module power_mode_clock_switch #(
    parameter int CPU_READY = pmc_pkg::CPU_READY_CYC,
    parameter int OST_COUNT = pmc_pkg::OST_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sleep_instr,
    input  wire logic        wake_irq,
    input  wire logic        wdt_timeout,
    input  wire logic        pri_osc_ready,
    input  wire logic        pri_osc_tick,
    input  wire logic        timer_osc_ready,
    input  wire logic        int_osc_ready,
    output logic [1:0]       clk_mux_sel,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             pri_osc_run,
    output logic             timer_osc_run,
    output logic             int_osc_run,
    output logic             low_freq_osc_run,
    output logic             cpu_ready
);
    import pmc_pkg::*;

    // ======================================================================
    // pin synchronisers
    logic [2:0] rdy_s1_q, rdy_s2_q;
    logic       tick_s1_q, tick_s2_q, tick_s3_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_s1_q  <= 3'h0;
            rdy_s2_q  <= 3'h0;
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end else begin
            rdy_s1_q  <= {int_osc_ready, timer_osc_ready, pri_osc_ready};
            rdy_s2_q  <= rdy_s1_q;
            tick_s1_q <= pri_osc_tick;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end
    wire pri_rdy   = rdy_s2_q[0];
    wire timer_rdy = rdy_s2_q[1];
    wire int_rdy   = rdy_s2_q[2];
    wire tick_edge = tick_s2_q & ~tick_s3_q;

    // ======================================================================
    // registers
    logic [7:0] osc_ctrl_q;
    logic       tosc_en_q;
    logic [3:0] cfg_q;
    logic       pri_flag_q, sec_flag_q;
    wire wr_ok = avs_write & ~avs_waitrequest;
    wire rd_ok = avs_read & ~avs_waitrequest;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_ctrl_q <= CTRL_RESET;
        end else if (wr_ok && avs_address == ADDR_OSC_CTRL) begin
            osc_ctrl_q <= {avs_writedata[IDLE_EN_BIT], 5'h00, avs_writedata[1:0]};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tosc_en_q <= 1'b0;
            cfg_q     <= 4'h0;
        end else if (wr_ok) begin
            if (avs_address == ADDR_TIMER_CTRL) begin
                tosc_en_q <= avs_writedata[TOSC_EN_BIT];
            end
            if (avs_address == ADDR_CFG) begin
                cfg_q <= avs_writedata[3:0];
            end
        end
    end

    wire       idle_en   = osc_ctrl_q[IDLE_EN_BIT];
    wire [1:0] src_sel   = osc_ctrl_q[1:0];
    wire       wdt_en    = cfg_q[CFG_WDT_BIT];
    wire       fscm_en   = cfg_q[CFG_FSCM_BIT];
    wire       two_speed = cfg_q[CFG_TWO_SPEED];
    wire       crystal   = cfg_q[CFG_CRYSTAL];

    // one wait state keeps read data from a flip-flop
    logic rd_pend_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= avs_read & ~rd_pend_q;
        end
    end
    assign avs_waitrequest = avs_read & ~rd_pend_q;

    // ======================================================================
    // sequencer state
    mode_t      state_q;
    logic [1:0] cur_src_q, tgt_src_q;
    logic [3:0] sw_cnt_q;
    logic [15:0] dly_cnt_q;
    logic [10:0] ost_cnt_q;
    logic       ost_done_q;
    logic       pri_warm_q;

    function automatic logic src_ready(input logic [1:0] s, input logic pr,
                                       input logic tr, input logic ir);
        case (s)
            SRC_PRI:   src_ready = pr;
            SRC_TIMER: src_ready = tr;
            SRC_INT:   src_ready = ir;
            default:   src_ready = 1'b0;
        endcase
    endfunction

    // timer select ignored when timer osc disabled
    wire sel_legal = (src_sel != SRC_NONE) && !(src_sel == SRC_TIMER && !tosc_en_q);
    // crystal primary must finish start-up count
    wire pri_usable = pri_rdy && (!crystal || ost_done_q);
    wire tgt_rdy = (tgt_src_q == SRC_PRI) ? pri_usable :
                   src_ready(tgt_src_q, pri_rdy, timer_rdy, int_rdy);
    wire wake_evt = wake_irq | wdt_timeout;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ost_cnt_q  <= 11'h000;
            ost_done_q <= 1'b0;
        end else if (!pri_osc_run) begin
            ost_cnt_q  <= 11'h000;
            ost_done_q <= 1'b0;
        end else if (tick_edge && !ost_done_q) begin
            ost_cnt_q  <= ost_cnt_q + 11'h001;
            ost_done_q <= (ost_cnt_q == 11'(OST_COUNT - 1));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pri_warm_q <= 1'b0;
        end else begin
            pri_warm_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= ST_WAKE_WAIT;
            cur_src_q <= SRC_NONE;
            tgt_src_q <= SRC_PRI;
            sw_cnt_q  <= 4'h0;
            dly_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (sleep_instr) begin
                        if (idle_en) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_SLEEP;
                        end
                    end else if (sel_legal && src_sel != cur_src_q) begin
                        tgt_src_q <= src_sel;
                        sw_cnt_q  <= 4'h0;
                        state_q   <= ST_SWITCH;
                    end
                end
                ST_SWITCH: begin
                    // old source keeps running until target ready
                    if (tgt_rdy) begin
                        // two old plus four new cycles
                        if (sw_cnt_q == 4'(OLD_CYCLES + NEW_CYCLES - 1)) begin
                            cur_src_q <= tgt_src_q;
                            state_q   <= ST_RUN;
                        end else begin
                            sw_cnt_q <= sw_cnt_q + 4'h1;
                        end
                    end
                end
                ST_IDLE: begin
                    if (wake_evt) begin
                        dly_cnt_q <= 16'h0000;
                        state_q   <= ST_CPU_DELAY;
                    end
                end
                ST_SLEEP: begin
                    if (wake_evt) begin
                        // wake into run mode of current select
                        tgt_src_q <= sel_legal ? src_sel : SRC_INT;
                        cur_src_q <= (two_speed || fscm_en) ? SRC_INT : SRC_NONE;
                        state_q   <= ST_WAKE_WAIT;
                    end
                end
                ST_WAKE_WAIT: begin
                    // unclocked or internal until source ready
                    if (!pri_warm_q && two_speed) begin
                        cur_src_q <= SRC_INT;
                    end else if (tgt_rdy) begin
                        cur_src_q <= tgt_src_q;
                        dly_cnt_q <= 16'h0000;
                        state_q   <= ST_CPU_DELAY;
                    end
                end
                ST_CPU_DELAY: begin
                    if (dly_cnt_q == 16'(CPU_READY - 1)) begin
                        state_q <= ST_RUN;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 16'h0001;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // ======================================================================
    // status flags
    // flags follow the source driving the device
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pri_flag_q <= 1'b0;
            sec_flag_q <= 1'b0;
        end else if (state_q == ST_SLEEP) begin
            pri_flag_q <= 1'b0;
            sec_flag_q <= 1'b0;
        end else if (state_q != ST_IDLE) begin
            pri_flag_q <= (cur_src_q == SRC_PRI);
            sec_flag_q <= (cur_src_q == SRC_TIMER);
        end
    end

    // ======================================================================
    // clock gating and oscillator enables
    wire sleeping = (state_q == ST_SLEEP);
    assign clk_mux_sel   = cur_src_q;
    assign cpu_clk_en    = (state_q == ST_RUN || state_q == ST_SWITCH) && cur_src_q != SRC_NONE;
    assign periph_clk_en = !sleeping && cur_src_q != SRC_NONE;
    assign cpu_ready     = (state_q == ST_RUN || state_q == ST_SWITCH);
    // primary stops when another source is in use and primary is not the target
    assign pri_osc_run = !sleeping && (cur_src_q == SRC_PRI || tgt_src_q == SRC_PRI);
    // timer osc keeps running when enabled
    assign timer_osc_run = tosc_en_q;
    assign int_osc_run   = !sleeping && (cur_src_q == SRC_INT || tgt_src_q == SRC_INT
                                         || two_speed || fscm_en);
    // low-frequency osc kept for watchdog or monitor
    assign low_freq_osc_run = wdt_en || fscm_en || (int_osc_run && cur_src_q == SRC_INT);

    // ======================================================================
    // read data, unmapped reads return zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !rd_pend_q) begin
            case (avs_address)
                ADDR_OSC_CTRL: avs_readdata <= {24'h0, osc_ctrl_q[7:4], pri_flag_q,
                                                osc_ctrl_q[2:0]};
                ADDR_TIMER_CTRL: avs_readdata <= {25'h0, sec_flag_q, 2'h0, tosc_en_q, 3'h0};
                ADDR_CFG:      avs_readdata <= {28'h0, cfg_q};
                ADDR_STATUS:   avs_readdata <= {26'h0, 3'(state_q), cur_src_q, cpu_ready};
                default:       avs_readdata <= 32'h0;
            endcase
        end
    end
endmodule // power_mode_clock_switch

// ---- verilog/pmc_pkg.sv ----
// constants for the power mode and clock switch controller
// assumes one 100 MHz register clock; oscillators report ready levels from their own domains
// ==========================================================================
package pmc_pkg;
    // ======================================================================
    // register map
    localparam logic [3:0] ADDR_OSC_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_TIMER_CTRL = 4'h4;
    localparam logic [3:0] ADDR_CFG        = 4'h8;
    localparam logic [3:0] ADDR_STATUS     = 4'hc;
    localparam int IDLE_EN_BIT   = 7;
    localparam int PRI_FLAG_BIT  = 3;
    localparam int SEC_FLAG_BIT  = 6;
    localparam int TOSC_EN_BIT   = 3;
    localparam int CFG_WDT_BIT   = 0;
    localparam int CFG_FSCM_BIT  = 1;
    localparam int CFG_TWO_SPEED = 2;
    localparam int CFG_CRYSTAL   = 3;
    // ======================================================================
    // source select encodings
    localparam logic [1:0] SRC_PRI   = 2'h2;
    localparam logic [1:0] SRC_TIMER = 2'h1;
    localparam logic [1:0] SRC_INT   = 2'h3;
    localparam logic [1:0] SRC_NONE  = 2'h0;
    // ======================================================================
    // timing
    localparam int OLD_CYCLES  = 2;
    localparam int NEW_CYCLES  = 4;
    localparam int OST_CYCLES  = 1024;
    localparam int CPU_READY_NS = 100;
    localparam int CLK_NS       = 10;
    localparam int CPU_READY_CYC = (CPU_READY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    typedef enum logic [2:0] {
        ST_RUN, ST_SWITCH, ST_SLEEP, ST_IDLE, ST_WAKE_WAIT, ST_CPU_DELAY
    } mode_t;
endpackage

// ---- bench/power_mode_clock_switch_asserts.sv ----
// concurrent checks for the power mode clock switch
// sees only top ports; bound to the design at the foot of this file
`timescale 1ns/10ps
module power_mode_clock_switch_asserts #(
    parameter int CPU_READY = 4,
    parameter int OST_COUNT = 8
) (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        sleep_instr,
    input wire logic        pri_osc_ready,
    input wire logic [1:0]  clk_mux_sel,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        pri_osc_run,
    input wire logic        timer_osc_run,
    input wire logic        low_freq_osc_run,
    input wire logic        cpu_ready
);
    import pmc_pkg::*;
    logic       idle_q;
    logic       ten_q;
    logic       lf_q;
    logic [7:0] low_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ======================================================================
    // shadow of software settings, taken from the bus
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_q <= 1'b0;
            ten_q  <= 1'b0;
            lf_q   <= 1'b0;
        end else if (avs_write) begin
            if (avs_address == ADDR_OSC_CTRL) idle_q <= avs_writedata[IDLE_EN_BIT];
            if (avs_address == ADDR_TIMER_CTRL) ten_q <= avs_writedata[TOSC_EN_BIT];
            if (avs_address == ADDR_CFG) lf_q <= avs_writedata[CFG_WDT_BIT];
        end
    end
    // saturating count of cycles with the cpu held off
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) low_q <= 8'h00;
        else if (cpu_ready) low_q <= 8'h00;
        else if (low_q != 8'hff) low_q <= low_q + 8'h01;
    end
    // ======================================================================
    // cpu-ready interval and source switch timing
    chk_ready_delay: assert property ($rose(cpu_ready) |-> low_q >= CPU_READY)
        else $error("cpu ready came too early");
    chk_pri_ready_sel: assert property ($changed(clk_mux_sel) && clk_mux_sel == SRC_PRI
        |-> $past(pri_osc_ready, 2))
        else $error("primary selected before ready");
    chk_int_switch_time: assert property (avs_write && avs_address == ADDR_OSC_CTRL
        && avs_writedata[1:0] == SRC_INT && cpu_clk_en |-> ##[1:60] clk_mux_sel == SRC_INT)
        else $error("internal switch too slow");
    // primary stopped
    // a switch while running stops it, as does sleep; a two-speed wake keeps it warming up
    chk_pri_stop: assert property ($changed(clk_mux_sel) && clk_mux_sel[0] && cpu_clk_en
        |-> ##[0:2] !pri_osc_run)
        else $error("primary left running");
    chk_lf_osc_run: assert property (lf_q |-> low_freq_osc_run)
        else $error("low-frequency osc stopped under watchdog");
    chk_sleep_stops: assert property (sleep_instr && cpu_clk_en && !idle_q
        |-> ##[1:3] !periph_clk_en && !pri_osc_run && !cpu_clk_en)
        else $error("sleep left clocks running");
    chk_idle_keeps: assert property (sleep_instr && cpu_clk_en && idle_q
        |-> ##[1:3] !cpu_clk_en && periph_clk_en)
        else $error("idle entry wrong");
    chk_timer_asleep: assert property (ten_q && !periph_clk_en |-> timer_osc_run)
        else $error("timer osc stopped in sleep");
    cover property (sleep_instr && idle_q);
    cover property (sleep_instr && !idle_q);
    cover property ($changed(clk_mux_sel) && clk_mux_sel == SRC_TIMER);
    cover property ($changed(clk_mux_sel) && clk_mux_sel == SRC_INT && !cpu_clk_en);
endmodule // power_mode_clock_switch_asserts

bind power_mode_clock_switch power_mode_clock_switch_asserts #(
    .CPU_READY(CPU_READY), .OST_COUNT(OST_COUNT)) chk_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .sleep_instr(sleep_instr),
    .pri_osc_ready(pri_osc_ready), .clk_mux_sel(clk_mux_sel), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .pri_osc_run(pri_osc_run),
    .timer_osc_run(timer_osc_run), .low_freq_osc_run(low_freq_osc_run),
    .cpu_ready(cpu_ready));

// ---- bench/osc_model.sv ----
// oscillator sources behind the clock switch
// ready rises a fixed count of edges after run, drops at the next ref_clk edge once stopped
`timescale 1ns/10ps
module osc_model #(
    parameter int PRI_UP = 30,
    parameter int TMR_UP = 12,
    parameter int INT_UP = 3
) (
    input  wire logic ref_clk,
    input  wire logic primary_run_mode,
    input  wire logic tmr_run,
    input  wire logic int_run,
    output logic      pri_rdy,
    output logic      tmr_rdy,
    output logic      int_rdy,
    output logic      pri_tick
);
    int pc = 0;
    int tc = 0;
    int ic = 0;
    // ======================================================================
    // slow starts so the switch really has to wait
    always @(posedge ref_clk) begin
        pc <= primary_run_mode ? pc + 1 : 0;
        tc <= tmr_run ? tc + 1 : 0;
        ic <= int_run ? ic + 1 : 0;
    end
    assign pri_rdy = pc >= PRI_UP;
    assign tmr_rdy = tc >= TMR_UP;
    assign int_rdy = ic >= INT_UP;
    // crystal stands still while stopped; rate unrelated to ref_clk
    initial begin
        pri_tick = 1'b0;
        forever #13 pri_tick = primary_run_mode ? ~pri_tick : 1'b0;
    end
endmodule // osc_model

// ---- bench/power_mode_clock_switch_tb.sv ----
// self-checking bench for the power mode clock switch
// drives bus and cpu events; oscillators come from osc_model
`timescale 1ns/10ps
module power_mode_clock_switch_tb;
    import pmc_pkg::*;
    localparam int CR = 4;
    logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, pins;
    logic [2:0]  ev;
    logic [1:0]  clk_mux_sel;
    logic        pri_rdy, tmr_rdy, int_rdy, tick, cpu_clk_en, periph_clk_en, cpu_ready;
    logic        primary_run_mode, tmr_run, int_run, lf_run;
    int          err_total = 0;
    int          num_checks = 0;
    assign pins = {28'h0, tmr_run, primary_run_mode, periph_clk_en, cpu_clk_en};
    power_mode_clock_switch #(.CPU_READY(CR), .OST_COUNT(8)) power_mode_clock_switch_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_instr(ev[0]), .wake_irq(ev[1]),
        .wdt_timeout(ev[2]), .pri_osc_ready(pri_rdy), .pri_osc_tick(tick),
        .timer_osc_ready(tmr_rdy), .int_osc_ready(int_rdy), .clk_mux_sel(clk_mux_sel),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .pri_osc_run(primary_run_mode),
        .timer_osc_run(tmr_run), .int_osc_run(int_run), .low_freq_osc_run(lf_run),
        .cpu_ready(cpu_ready));
    osc_model osc_model_i (.ref_clk(ref_clk), .primary_run_mode(primary_run_mode), .tmr_run(tmr_run),
        .int_run(int_run), .pri_rdy(pri_rdy), .tmr_rdy(tmr_rdy), .int_rdy(int_rdy),
        .pri_tick(tick));
    // ======================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // bus write; request held until waitrequest is seen low at an edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge ref_clk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge ref_clk iff avs_waitrequest === 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        chk(d, exp);
        @(posedge ref_clk);
    endtask
    // one-cycle cpu event: 0 sleep, 1 interrupt, 2 watchdog
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge ref_clk);
        ev <= 3'h0;
        @(posedge ref_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ======================================================================
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // whole run needs well under 2000 cycles
    initial begin
        #100000;
        err_total++;
        end_sim();
    end
    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        ev = 3'h0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk iff cpu_ready === 1'b1);
        rdc(ADDR_OSC_CTRL, 32'h0a);
        chk(32'(clk_mux_sel), 32'(SRC_PRI));
        rdc(ADDR_TIMER_CTRL, 32'h0);
        rdc(4'h2, 32'h0);
        wr(ADDR_OSC_CTRL, 32'h01);
        repeat (40) @(posedge ref_clk);
        chk(32'(clk_mux_sel), 32'(SRC_PRI));
        wr(ADDR_TIMER_CTRL, 32'h08);
        wr(ADDR_OSC_CTRL, 32'h01);
        chk(32'(clk_mux_sel), 32'(SRC_PRI));
        @(posedge ref_clk iff clk_mux_sel === SRC_TIMER);
        rdc(ADDR_OSC_CTRL, 32'h01);
        rdc(ADDR_TIMER_CTRL, 32'h48);
        chk(pins, 32'h0b);
        wr(ADDR_OSC_CTRL, 32'h02);
        chk(32'(clk_mux_sel), 32'(SRC_TIMER));
        @(posedge ref_clk iff clk_mux_sel === SRC_PRI);
        rdc(ADDR_OSC_CTRL, 32'h0a);
        rdc(ADDR_TIMER_CTRL, 32'h08);
        chk(pins, 32'h0f);
        wr(ADDR_OSC_CTRL, 32'h03);
        @(posedge ref_clk iff clk_mux_sel === SRC_INT);
        rdc(ADDR_OSC_CTRL, 32'h03);
        chk(pins, 32'h0b);
        wr(ADDR_OSC_CTRL, 32'h02);
        chk(32'(clk_mux_sel), 32'(SRC_INT));
        @(posedge ref_clk iff clk_mux_sel === SRC_PRI);
        rdc(ADDR_OSC_CTRL, 32'h0a);
        wr(ADDR_CFG, 32'h01);
        chk(32'(lf_run), 32'h1);
        pulse(0);
        @(posedge ref_clk iff periph_clk_en === 1'b0);
        rdc(ADDR_OSC_CTRL, 32'h02);
        chk(pins, 32'h08);
        chk(32'(lf_run), 32'h1);
        pulse(1);
        @(posedge ref_clk iff cpu_ready === 1'b1);
        rdc(ADDR_OSC_CTRL, 32'h0a);
        wr(ADDR_OSC_CTRL, 32'h82);
        pulse(0);
        @(posedge ref_clk iff cpu_clk_en === 1'b0);
        rdc(ADDR_OSC_CTRL, 32'h8a);
        repeat (20) @(posedge ref_clk);
        chk(pins, 32'h0e);
        pulse(2);
        @(posedge ref_clk iff cpu_ready === 1'b1);
        chk(pins, 32'h0f);
        rdc(ADDR_OSC_CTRL, 32'h8a);
        wr(ADDR_OSC_CTRL, 32'h02);
        pulse(0);
        @(posedge ref_clk iff periph_clk_en === 1'b0);
        chk(pins, 32'h08);
        pulse(1);
        @(posedge ref_clk iff cpu_ready === 1'b1);
        // two-speed wake clocks peripherals from the internal block, cpu clock held off, while primary warms up
        wr(ADDR_CFG, 32'h05);
        pulse(0);
        @(posedge ref_clk iff periph_clk_en === 1'b0);
        pulse(1);
        chk(32'(clk_mux_sel), 32'(SRC_INT));
        chk(pins, 32'h0e);
        chk(32'(int_run), 32'h1);
        @(posedge ref_clk iff cpu_ready === 1'b1);
        chk(32'(clk_mux_sel), 32'(SRC_PRI));
        rdc(ADDR_OSC_CTRL, 32'h0a);
        end_sim();
    end
endmodule // power_mode_clock_switch_tb
